/* File: hw/sarc_top.sv */
// Converter conversion control and parallel result readout
`timescale 1ns/1ps
`include "sarc_map.svh"
module sarc_top
   import sarc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        conversion_trigger_n,
   input  wire logic        cs_n,
   input  wire logic        rd_n,
   input  wire logic        byte_sel,
   input  wire logic [15:0] sample_code,
   output logic             busy,
   output logic             sampling,
   output logic [15:0]      output_data_bus,
   output logic [15:0]      output_data_bus_oe
);
   sarc_ctrl_type  pins_raw;
   sarc_ctrl_type  pins;
   sarc_ctrl_type  prev_q;
   sarc_state_type state_q;
   logic [`SARC_CNT_W-1:0] cnt_q;
   logic [15:0]    hold_q;
   logic [15:0]    result_q;
   logic [15:0]    bus_q;
   logic [15:0]    oe_q;
   logic           busy_q;
   logic           sampling_q;
   logic           trig_fall;
   logic           cs_fall;
   logic           conv_done;
   logic           abort;

   localparam logic [`SARC_CNT_W-1:0] CONV_LAST =
      `SARC_CNT_W'(`SARC_CONV_CYC - 1);

   // Arranges a 16-bit result for the chosen byte order
   function automatic logic [15:0] lane_map(input logic [15:0] r,
                                            input logic        hi_sel);
      if (hi_sel)
         lane_map = {r[7:0], `SARC_LOW_FILL};
      else
         lane_map = r;
   endfunction

   assign pins_raw = '{cs_n: cs_n, rd_n: rd_n, byte_sel: byte_sel,
                       trig_n: conversion_trigger_n};

   sarc_sync u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pins_in  (pins_raw),
      .pins_out (pins)
   );

   always_ff @(posedge core_clk) begin
      if (!rst_n)
         prev_q <= '1;
      else
         prev_q <= pins;
   end

   // A trigger counts only with select low at its falling edge
   assign trig_fall = prev_q.trig_n && !pins.trig_n && !pins.cs_n;
   assign cs_fall   = prev_q.cs_n && !pins.cs_n;
   assign conv_done = (state_q == SARC_CONV) && (cnt_q == CONV_LAST);
   // Self-clear abort: new trigger or select fall mid-conversion
   assign abort     = (state_q == SARC_CONV) && (trig_fall || cs_fall);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q <= SARC_SAMPLE;
         cnt_q   <= '0;
      end else begin
         unique case (state_q)
            SARC_SAMPLE, SARC_IDLE: begin
               cnt_q <= '0;
               if (trig_fall)
                  state_q <= SARC_CONV;
               else if (state_q == SARC_IDLE && cs_fall)
                  state_q <= SARC_SAMPLE;
            end
            SARC_CONV: begin
               cnt_q <= cnt_q + `SARC_CNT_W'(1);
               if (abort) begin
                  state_q <= SARC_SAMPLE;
                  cnt_q   <= '0;
               end else if (conv_done) begin
                  // Select high at end: sampling waits for select fall
                  state_q <= pins.cs_n ? SARC_IDLE : SARC_SAMPLE;
               end
            end
            default: begin
               state_q <= SARC_SAMPLE;
               cnt_q   <= '0;
            end
         endcase
      end
   end

   // Sample frozen at the trigger edge, so later input motion is ignored
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         hold_q <= `SARC_ZERO_CODE;
      else if (trig_fall && state_q != SARC_CONV)
         hold_q <= sample_code;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n)
         result_q <= `SARC_ZERO_CODE;
      else if (abort)
         result_q <= `SARC_ZERO_CODE;
      else if (conv_done)
         result_q <= hold_q;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         busy_q     <= 1'b0;
         sampling_q <= 1'b1;
      end else begin
         busy_q     <= (state_q == SARC_CONV) && !conv_done && !abort
                       || ((state_q != SARC_CONV) && trig_fall);
         sampling_q <= (state_q == SARC_SAMPLE) && !trig_fall
                       || (state_q == SARC_CONV && abort)
                       || (conv_done && !pins.cs_n && !abort)
                       || (state_q == SARC_IDLE && cs_fall
                           && !trig_fall);
      end
   end

   // Bus enabled only during a read; result shows from busy fall
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bus_q <= `SARC_ZERO_CODE;
         oe_q  <= '0;
      end else begin
         oe_q  <= {16{!pins.cs_n && !pins.rd_n}};
         bus_q <= lane_map(conv_done && !abort ? hold_q : result_q,
                           pins.byte_sel);
      end
   end

   assign busy               = busy_q;
   assign sampling           = sampling_q;
   assign output_data_bus    = bus_q;
   assign output_data_bus_oe = oe_q;

   sequence s_conv_start;
      $rose(busy_q);
   endsequence

   // Nine busy cycles, one past what a single repeat may count
   sequence s_conv_run;
      busy_q [*8] ##1 busy_q;
   endsequence

   sequence s_conv_end;
      conv_done && !abort;
   endsequence

   property p_conv_len;
      @(posedge core_clk) disable iff (!rst_n)
         s_conv_start ##0 (state_q == SARC_CONV) ##1 (!abort [*8])
         |-> busy_q ##1 !busy_q;
   endproperty

   a_busy_on_trig: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (trig_fall && state_q != SARC_CONV) |=> busy_q)
      else $error("busy did not rise after trigger");

   a_conv_length: assert property (p_conv_len)
      else $error("conversion length wrong");

   a_busy_bounded: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      s_conv_run |=> !busy_q)
      else $error("busy stayed high too long");

   a_bus_enable: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (oe_q != '0) |-> $past(!pins.cs_n && !pins.rd_n))
      else $error("bus driven outside a read");

   a_bus_release: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $past(pins.cs_n || pins.rd_n) |-> (oe_q == 16'h0000))
      else $error("bus still driven after a read");

   // Reset leaves the lanes zero, so the first edge after it is skipped
   a_byte_fill: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) && $past(pins.byte_sel)
      |-> (bus_q[7:0] == `SARC_LOW_FILL))
      else $error("low lane not all ones in byte mode");

   a_abort_clear: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      abort |=> (result_q == `SARC_ZERO_CODE) && !busy_q)
      else $error("abort did not clear result");

   a_result_hold: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      s_conv_end |=> (result_q == $past(hold_q)))
      else $error("result not taken from held sample");

   a_sample_restart: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state_q == SARC_IDLE && cs_fall && !trig_fall) |=> sampling_q)
      else $error("sampling not restarted on select fall");

   a_idle_wait: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (s_conv_end ##0 pins.cs_n)
      |=> (state_q == SARC_IDLE) && !sampling_q)
      else $error("sampling started with select high");

   a_end_sample: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (s_conv_end ##0 !pins.cs_n) |=> sampling_q && !busy_q)
      else $error("sampling not started at busy fall");
endmodule

/* File: hw/sarc_map.svh */
// Constants for the converter readout control block
`ifndef SARC_MAP_SVH
`define SARC_MAP_SVH
`define SARC_CLK_PERIOD_NS   40
`define SARC_TRIG_MIN_NS     20
`define SARC_CONV_NS         360
`define SARC_ACQ_NS          100
`define SARC_QUIET_PRE_NS    50
`define SARC_QUIET_POST_NS   40
`define SARC_RST_MIN_NS      25
`define SARC_ABORT_MAX_NS    50
// Longest time rounds down, at least one cycle
`define SARC_CONV_CYC  ((`SARC_CONV_NS / `SARC_CLK_PERIOD_NS) < 1 ? 1 : \
                        (`SARC_CONV_NS / `SARC_CLK_PERIOD_NS))
// Least time rounds up
`define SARC_ACQ_CYC   ((`SARC_ACQ_NS + `SARC_CLK_PERIOD_NS - 1) / \
                        `SARC_CLK_PERIOD_NS)
`define SARC_DATA_W      16
`define SARC_ZERO_CODE   16'h0000
`define SARC_FULL_CODE   16'hffff
`define SARC_LOW_FILL    8'hff
`define SARC_CNT_W       4
`endif

/* File: hw/sarc_pkg.sv */
// Types shared by the converter readout control block
package sarc_pkg;
   typedef enum logic [2:0] {
      SARC_SAMPLE = 3'b001,
      SARC_CONV   = 3'b010,
      SARC_IDLE   = 3'b100
   } sarc_state_type;

   typedef struct packed {
      logic       cs_n;
      logic       rd_n;
      logic       byte_sel;
      logic       trig_n;
   } sarc_ctrl_type;

   typedef struct packed {
      logic [15:0] data;
      logic [15:0] oe;
   } sarc_bus_type;
endpackage

/* File: hw/sarc_sync.sv */
// Two-stage synchroniser for the control pins
`timescale 1ns/1ps
`include "sarc_map.svh"
module sarc_sync
   import sarc_pkg::*;
(
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   input  wire sarc_ctrl_type pins_in,
   output sarc_ctrl_type      pins_out
);
   sarc_ctrl_type meta_q;
   sarc_ctrl_type sync_q;

   // Idle level is all high: strobes released, byte select high is harmless
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= pins_in;
         sync_q <= meta_q;
      end
   end

   assign pins_out = sync_q;
endmodule

/* File: verification/sarc_host_model.sv */
// Host controller model driving the converter control pins
`timescale 1ns/1ps
module sarc_host_model (
   input  wire logic core_clk,
   output logic      trig_n,
   output logic      cs_n,
   output logic      rd_n,
   output logic      byte_sel
);
   initial begin
      trig_n = 1'b1;
      cs_n = 1'b1;
      rd_n = 1'b1;
      byte_sel = 1'b0;
   end
   // Reads are always closed here, so the quiet zone holds
   task automatic start_conv(input logic sel, input int acq);
      @(negedge core_clk);
      cs_n = ~sel;
      repeat (acq) @(negedge core_clk);
      trig_n = 1'b0;
      repeat (2) @(negedge core_clk);
      trig_n = 1'b1;
   endtask
   task automatic open_read(input logic sel, input logic bsel);
      @(negedge core_clk);
      cs_n = ~sel;
      byte_sel = bsel;
      @(negedge core_clk);
      rd_n = 1'b0;
   endtask
   // Strobe first, select a cycle later
   task automatic close_read(input logic drop_cs);
      @(negedge core_clk);
      rd_n = 1'b1;
      @(negedge core_clk);
      if (drop_cs) begin
         cs_n = 1'b1;
      end
   endtask
   // Select may rise mid-conversion; a fall there aborts it
   task automatic set_cs(input logic sel);
      @(negedge core_clk);
      cs_n = ~sel;
   endtask
endmodule

/* File: verification/sarc_adc_conversion_read_control_tb_top.sv */
// Self-checking bench for the converter control and readout block
`timescale 1ns/1ps
`include "sarc_map.svh"
module sarc_adc_conversion_read_control_tb_top;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        trig_n;
   logic        cs_n;
   logic        rd_n;
   logic        byte_sel;
   logic [15:0] code = 16'h0000;
   logic        busy;
   logic        sampling;
   logic [15:0] bus;
   logic [15:0] oe;
   int          err_count = 0;
   int          check_count = 0;
   int          cyc = 0;
   logic [15:0] codes [4] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff};
   always #20 core_clk = ~core_clk;
   sarc_top u_dut (.core_clk(core_clk), .rst_n(rst_n),
      .conversion_trigger_n(trig_n), .cs_n(cs_n), .rd_n(rd_n),
      .byte_sel(byte_sel), .sample_code(code), .busy(busy),
      .sampling(sampling), .output_data_bus(bus),
      .output_data_bus_oe(oe));
   sarc_host_model u_host (.core_clk(core_clk), .trig_n(trig_n),
      .cs_n(cs_n), .rd_n(rd_n), .byte_sel(byte_sel));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (err_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic conv_start(input logic [15:0] c);
      int n;
      n = 0;
      @(negedge core_clk);
      code = c;
      u_host.start_conv(1'b1, 3);
      while (busy !== 1'b1 && n < 8) begin
         tick(1);
         n++;
      end
      check(16'(busy), 16'h0001);
      check(16'(sampling), 16'h0000);
   endtask
   // Busy fall is the ready event
   task automatic conv_full(input logic [15:0] c);
      int n;
      n = 0;
      conv_start(c);
      while (busy === 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      check(16'(n), 16'(`SARC_CONV_CYC));
      tick(2);
      check(16'(sampling), 16'h0001);
   endtask
   task automatic read_chk(input logic bsel, input logic drop,
                           input logic [15:0] exp);
      u_host.open_read(1'b1, bsel);
      tick(4);
      check(oe, 16'hffff);
      check(bus, exp);
      u_host.close_read(drop);
      tick(4);
      check(oe, 16'h0000);
   endtask
   task automatic t_codes();
      foreach (codes[i]) begin
         conv_full(codes[i]);
         read_chk(1'b0, 1'b0, codes[i]);
         read_chk(1'b1, 1'b1, {codes[i][7:0], `SARC_LOW_FILL});
      end
   endtask
   task automatic t_refused();
      u_host.start_conv(1'b0, 3);
      tick(6);
      check(16'(busy), 16'h0000);
      u_host.open_read(1'b0, 1'b0);
      tick(4);
      check(oe, 16'h0000);
      u_host.close_read(1'b1);
   endtask
   // Second trigger with select low cuts the conversion short
   task automatic t_abort();
      conv_start(16'h5a5a);
      u_host.start_conv(1'b1, 0);
      tick(5);
      check(16'(busy), 16'h0000);
      read_chk(1'b0, 1'b1, 16'h0000);
   endtask
   // Select high at the end parks sampling until select falls
   task automatic t_idle();
      int n;
      n = 0;
      conv_start(16'h1234);
      u_host.set_cs(1'b0);
      while (busy === 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      tick(2);
      check(16'(sampling), 16'h0000);
      u_host.set_cs(1'b1);
      tick(4);
      check(16'(sampling), 16'h0001);
      read_chk(1'b0, 1'b1, 16'h1234);
      // Select fall mid-conversion aborts like a reset
      conv_start(16'h3c3c);
      u_host.set_cs(1'b0);
      u_host.set_cs(1'b1);
      tick(5);
      check(16'(busy), 16'h0000);
      read_chk(1'b0, 1'b1, 16'h0000);
   endtask
   task automatic t_mid_reset();
      conv_start(16'ha5a5);
      @(negedge core_clk);
      rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      tick(1);
      check(16'(busy), 16'h0000);
      check(16'(sampling), 16'h0001);
      read_chk(1'b0, 1'b1, 16'h0000);
   endtask
   initial begin
      repeat (12) @(negedge core_clk);
      rst_n = 1'b1;
      tick(2);
      check(oe, 16'h0000);
      t_codes();
      t_refused();
      t_abort();
      t_idle();
      t_codes();
      t_mid_reset();
      finish_test();
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_count++;
         finish_test();
      end
   end
endmodule
